//--- rtl/nvmem_defines.svh
// Constants for the host controller of the battery-free store memory
`ifndef NVMEM_DEFINES_SVH
`define NVMEM_DEFINES_SVH

// ==========================================================
// Clock and timing
`define NV_CLK_MHZ       25
`define NV_HSB_LOW_US    20
`define NV_HSB_LOW_CYC   (`NV_HSB_LOW_US * `NV_CLK_MHZ)
`define NV_HSB_REQ_CYC   4
`define NV_RD_CYC        4
`define NV_WR_CYC        2
`define NV_RECALL_CYC    1000

// ==========================================================
// Software sequence addresses
`define NV_SEQ_A0        13'h0000
`define NV_SEQ_A1        13'h1555
`define NV_SEQ_A2        13'h0aaa
`define NV_SEQ_A3        13'h1fff
`define NV_SEQ_A4        13'h10f0
`define NV_SEQ_STORE     13'h0f0f
`define NV_SEQ_RECALL    13'h0f0e
`define NV_SEQ_LAST      3'h5

`endif

//--- rtl/nvmem_host.sv
// Host controller driving the 8K x 8 store/recall memory over its pins
// Operation
// - To block stores, host drives store/busy line high over the pull-down.
// - Store: six CE reads 0000,1555,0AAA,1FFF,10F0,0F0F; sixth starts store.
// - Recall: six CE reads 0000,1555,0AAA,1FFF,10F0,0F0E; sixth recalls.
// - Sequence counts only as consecutive reads in exactly that order.
// - Write strobe stays high through all six sequence cycles.
`timescale 1ns/1ps
`include "nvmem_defines.svh"

module nvmem_host
	import nvmem_pkg::*;
#(
	parameter int unsigned RD_CYC     = `NV_RD_CYC,
	parameter int unsigned WR_CYC     = `NV_WR_CYC,
	parameter int unsigned HSB_REQ    = `NV_HSB_REQ_CYC,
	parameter int unsigned HSB_LOW    = `NV_HSB_LOW_CYC,
	parameter int unsigned RECALL_CYC = `NV_RECALL_CYC
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	// User side
	input  wire logic        req_valid,
	input  wire op_type      req_op,
	input  wire logic [12:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	input  wire logic        store_inhibit,
	output logic             req_ready,
	output logic             done,
	output logic             rvalid,
	output logic      [7:0]  rdata,
	// Memory pins
	output logic             ce_n,
	output logic             we_n,
	output logic             oe_n,
	output logic      [12:0] addr,
	input  wire logic [7:0]  dq_i,
	output logic      [7:0]  dq_o,
	output logic             dq_oe_n,
	input  wire logic        hsb_i,
	output logic             hsb_o,
	output logic             hsb_oe_n
);
	// ======================================================
	// Pin synchronisers
	logic [7:0] dq_m_q, dq_s_q;
	logic       hsb_m_q, hsb_s_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dq_m_q  <= 8'h00;
			dq_s_q  <= 8'h00;
			hsb_m_q <= 1'b1;
			hsb_s_q <= 1'b1;
		end else begin
			dq_m_q  <= dq_i;
			dq_s_q  <= dq_m_q;
			hsb_m_q <= hsb_i;
			hsb_s_q <= hsb_m_q;
		end
	end

	// ======================================================
	// Sequencer
	state_type   state_q, state_d;
	op_type      op_q, op_d;
	logic [11:0] cnt_q, cnt_d;
	logic [2:0]  idx_q, idx_d;
	logic [12:0] uaddr_q, uaddr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic [12:0] rom_addr;
	logic        seq_op;
	logic        ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
	logic [12:0] addr_q, addr_d;
	logic [7:0]  dq_o_q, dq_o_d, rdata_q, rdata_d;
	logic        dq_oe_n_q, dq_oe_n_d;
	logic        hsb_o_q, hsb_o_d, hsb_oe_n_q, hsb_oe_n_d;
	logic        ready_q, ready_d, done_q, done_d, rvalid_q, rvalid_d;

	function automatic logic [11:0] cyc(input int unsigned n);
		cyc = n[11:0] - 12'h001;
	endfunction : cyc

	assign seq_op = (op_q == OP_STORE_SW) || (op_q == OP_RECALL_SW);

	nvmem_seq_rom u_rom (
		.clk    (clk),
		.nrst   (nrst),
		.idx    (idx_q),
		.recall (op_q == OP_RECALL_SW),
		.addr_q (rom_addr)
	);

	always_comb begin
		state_d    = state_q;
		op_d       = op_q;
		cnt_d      = cnt_q;
		idx_d      = idx_q;
		uaddr_d    = uaddr_q;
		wdata_d    = wdata_q;
		ce_n_d     = 1'b1;
		we_n_d     = 1'b1;
		oe_n_d     = 1'b1;
		addr_d     = addr_q;
		dq_o_d     = dq_o_q;
		dq_oe_n_d  = 1'b1;
		rdata_d    = rdata_q;
		done_d     = 1'b0;
		rvalid_d   = 1'b0;
		// Idle line: held high when stores are blocked, else released
		hsb_o_d    = 1'b1;
		hsb_oe_n_d = ~store_inhibit;
		unique case (state_q)
			ST_IDLE: begin
				idx_d = 3'h0;
				// Busy or disabled device refuses access; wait for line high
				if (req_valid && ready_q && hsb_s_q) begin
					op_d    = req_op;
					uaddr_d = req_addr;
					wdata_d = req_wdata;
					if (req_op == OP_STORE_HW) begin
						cnt_d   = cyc(HSB_REQ);
						state_d = ST_HSB_REQ;
					end else begin
						state_d = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				state_d = ST_SETUP;
			end
			ST_SETUP: begin
				addr_d = seq_op ? rom_addr : uaddr_q;
				if (op_q == OP_WRITE) begin
					dq_o_d    = wdata_q;
					dq_oe_n_d = 1'b0;
					cnt_d     = cyc(WR_CYC);
				end else begin
					cnt_d = cyc(RD_CYC);
				end
				state_d = ST_ACCESS;
			end
			ST_ACCESS: begin
				ce_n_d = 1'b0;
				// Sequence reads keep the gate high: detection ignores it
				oe_n_d = seq_op || (op_q == OP_WRITE);
				we_n_d = (op_q != OP_WRITE);
				dq_oe_n_d = (op_q != OP_WRITE);
				if (cnt_q == 12'h000) begin
					ce_n_d  = 1'b1;
					we_n_d  = 1'b1;
					oe_n_d  = 1'b1;
					rdata_d = dq_s_q;
					state_d = ST_GAP;
				end else begin
					cnt_d = cnt_q - 12'h001;
				end
			end
			ST_GAP: begin
				// Nothing else may slip between the six reads
				if (seq_op && idx_q != `NV_SEQ_LAST) begin
					idx_d   = idx_q + 3'h1;
					state_d = ST_LOAD;
				end else if (op_q == OP_STORE_SW) begin
					cnt_d   = cyc(HSB_LOW);
					state_d = ST_HSB_WAIT;
				end else if (op_q == OP_RECALL_SW) begin
					cnt_d   = cyc(RECALL_CYC);
					state_d = ST_RECALL;
				end else begin
					rvalid_d = (op_q == OP_READ);
					done_d   = 1'b1;
					state_d  = ST_IDLE;
				end
			end
			ST_HSB_REQ: begin
				hsb_o_d    = 1'b0;
				hsb_oe_n_d = 1'b0;
				if (cnt_q == 12'h000) begin
					state_d = ST_HSB_HOLD;
				end else begin
					cnt_d = cnt_q - 12'h001;
				end
			end
			ST_HSB_HOLD: begin
				// Release after the request cycles; wait on only if the low came back through sync
				hsb_oe_n_d = 1'b1;
				if (!hsb_s_q) begin
					cnt_d   = cyc(HSB_LOW);
					state_d = ST_HSB_WAIT;
				end else begin
					// Line held high elsewhere: give up rather than hang
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_HSB_WAIT: begin
				// Device may skip the store, but still waits for line high
				hsb_oe_n_d = 1'b1;
				if (cnt_q != 12'h000) begin
					cnt_d = cnt_q - 12'h001;
				end else if (hsb_s_q) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_RECALL: begin
				if (cnt_q == 12'h000) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 12'h001;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		ready_d = (state_d == ST_IDLE);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_IDLE;
			op_q       <= OP_READ;
			cnt_q      <= 12'h000;
			idx_q      <= 3'h0;
			uaddr_q    <= 13'h0000;
			wdata_q    <= 8'h00;
			ce_n_q     <= 1'b1;
			we_n_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			addr_q     <= 13'h0000;
			dq_o_q     <= 8'h00;
			dq_oe_n_q  <= 1'b1;
			rdata_q    <= 8'h00;
			hsb_o_q    <= 1'b1;
			hsb_oe_n_q <= 1'b1;
			ready_q    <= 1'b0;
			done_q     <= 1'b0;
			rvalid_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			op_q       <= op_d;
			cnt_q      <= cnt_d;
			idx_q      <= idx_d;
			uaddr_q    <= uaddr_d;
			wdata_q    <= wdata_d;
			ce_n_q     <= ce_n_d;
			we_n_q     <= we_n_d;
			oe_n_q     <= oe_n_d;
			addr_q     <= addr_d;
			dq_o_q     <= dq_o_d;
			dq_oe_n_q  <= dq_oe_n_d;
			rdata_q    <= rdata_d;
			hsb_o_q    <= hsb_o_d;
			hsb_oe_n_q <= hsb_oe_n_d;
			ready_q    <= ready_d;
			done_q     <= done_d;
			rvalid_q   <= rvalid_d;
		end
	end

	assign req_ready = ready_q;
	assign done      = done_q;
	assign rvalid    = rvalid_q;
	assign rdata     = rdata_q;
	assign ce_n      = ce_n_q;
	assign we_n      = we_n_q;
	assign oe_n      = oe_n_q;
	assign addr      = addr_q;
	assign dq_o      = dq_o_q;
	assign dq_oe_n   = dq_oe_n_q;
	assign hsb_o     = hsb_o_q;
	assign hsb_oe_n  = hsb_oe_n_q;

	// ======================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_seq_read;
		seq_op && !ce_n_q;
	endsequence

	sequence s_last_gap;
		state_q == ST_GAP && op_q == OP_STORE_SW && idx_q == `NV_SEQ_LAST;
	endsequence

	a_seq_we_high: assert property (s_seq_read |-> we_n_q && oe_n_q)
		else $error("write strobe or gate low in sequence");
	a_seq_gate_off: assert property (s_seq_read |-> dq_oe_n_q)
		else $error("data driven during sequence read");
	a_store_wait: assert property (s_last_gap |=> state_q == ST_HSB_WAIT
		[*8])
		else $error("software store not waited on");
	a_inhibit_drive: assert property (state_q == ST_IDLE && store_inhibit
		|=> !hsb_oe_n_q && hsb_o_q)
		else $error("store inhibit not driven high");
	a_no_access_busy: assert property (!hsb_s_q && state_q == ST_IDLE
		|=> state_q == ST_IDLE)
		else $error("access started while line low");
	a_write_data: assert property (!ce_n_q && !we_n_q |-> !dq_oe_n_q
		&& dq_o_q == wdata_q)
		else $error("write without data driven");
	a_seq_order: assert property (state_q == ST_SETUP && seq_op
		&& idx_q == 3'h1 |=> addr_q == `NV_SEQ_A1)
		else $error("sequence address out of order");
	a_hsb_req_low: assert property ($rose(state_q == ST_HSB_REQ)
		|=> !hsb_oe_n_q && !hsb_o_q)
		else $error("hardware store request not driven low");
	a_wait_min: assert property ($rose(state_q == ST_HSB_WAIT)
		|-> !done_q [*8])
		else $error("store wait ended too early");

endmodule : nvmem_host

//--- rtl/nvmem_pkg.sv
// Types shared by the host controller files
package nvmem_pkg;

	typedef enum logic [2:0] {
		OP_READ      = 3'b000,
		OP_WRITE     = 3'b001,
		OP_STORE_SW  = 3'b010,
		OP_RECALL_SW = 3'b011,
		OP_STORE_HW  = 3'b100
	} op_type;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_LOAD     = 4'b0001,
		ST_SETUP    = 4'b0010,
		ST_ACCESS   = 4'b0011,
		ST_GAP      = 4'b0100,
		ST_HSB_REQ  = 4'b0101,
		ST_HSB_HOLD = 4'b0110,
		ST_HSB_WAIT = 4'b0111,
		ST_RECALL   = 4'b1000
	} state_type;

endpackage : nvmem_pkg

//--- rtl/nvmem_seq_rom.sv
// Address table of the six-read store and recall sequences
`timescale 1ns/1ps
`include "nvmem_defines.svh"

module nvmem_seq_rom (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [2:0]  idx,
	input  wire logic        recall,
	output logic      [12:0] addr_q
);
	logic [12:0] addr_d;

	always_comb begin
		unique case (idx)
			3'h0:    addr_d = `NV_SEQ_A0;
			3'h1:    addr_d = `NV_SEQ_A1;
			3'h2:    addr_d = `NV_SEQ_A2;
			3'h3:    addr_d = `NV_SEQ_A3;
			3'h4:    addr_d = `NV_SEQ_A4;
			3'h5:    addr_d = recall ? `NV_SEQ_RECALL : `NV_SEQ_STORE;
			default: addr_d = `NV_SEQ_A0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= 13'h0000;
		end else begin
			addr_q <= addr_d;
		end
	end

endmodule : nvmem_seq_rom

//--- tb/nonvolatile_sram_mode_control_bench.sv
// Self-checking bench for the store/recall memory host controller
`timescale 1ns/1ps

module nonvolatile_sram_mode_control_bench
	import nvmem_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        req_valid = 1'b0;
	op_type      req_op = OP_READ;
	logic [12:0] req_addr = 13'h0000;
	logic [7:0]  req_wdata = 8'h00;
	logic        store_inhibit = 1'b0;
	logic        pf = 1'b0;
	logic        req_ready, done, rvalid, ce_n, we_n, oe_n, dq_oe_n;
	logic        hsb_o, hsb_oe_n, hsb_i, rv;
	logic [7:0]  rdata, dq_o, dq_i, got;
	logic [12:0] addr;
	int          miscompares = 0;
	int          num_checks = 0;
	int          base;

	always #20 clk = ~clk;

	nvmem_host #(.RECALL_CYC(10)) nvmem_host_i (.clk(clk), .nrst(nrst),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
		.req_wdata(req_wdata), .store_inhibit(store_inhibit),
		.req_ready(req_ready), .done(done), .rvalid(rvalid), .rdata(rdata),
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe_n(dq_oe_n), .hsb_i(hsb_i), .hsb_o(hsb_o),
		.hsb_oe_n(hsb_oe_n));
	nvmem_dev_model nvmem_dev_model_i (.ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
		.hsb_o(hsb_o), .hsb_oe_n(hsb_oe_n), .pf(pf), .dq_i(dq_i),
		.hsb_i(hsb_i));

	// ==========================================================
	// Shared tasks
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check

	// Request held until done, so it is taken once hsb allows
	task automatic do_op(input op_type op, input logic [12:0] a,
		input logic [7:0] wd);
		int n;
		@(negedge clk);
		req_op = op;
		req_addr = a;
		req_wdata = wd;
		req_valid = 1'b1;
		for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
		got = rdata;
		rv = rvalid;
		req_valid = 1'b0;
		if (n == 3000) begin
			miscompares++;
			wrap_up;
		end
	endtask : do_op

	task automatic pulse_pf;
		@(negedge clk);
		pf = 1'b1;
		@(negedge clk);
		pf = 1'b0;
		repeat (20) @(negedge clk);
	endtask : pulse_pf

	// ==========================================================
	// Scenarios
	task automatic t_rw;
		do_op(OP_WRITE, 13'h1fff, 8'ha5);
		do_op(OP_WRITE, 13'h0000, 8'h3c);
		check(nvmem_dev_model_i.mem[13'h0000], 8'h3c);
		do_op(OP_READ, 13'h1fff, 8'h00);
		check({rv, got}, 9'h1a5);
		do_op(OP_READ, 13'h0000, 8'h00);
		check(got, 8'h3c);
	endtask : t_rw

	task automatic t_abort;
		logic [12:0] s [5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff,
			13'h10f0};
		base = nvmem_dev_model_i.stores;
		for (int i = 0; i < 5; i++) do_op(OP_READ, s[i], 8'h00);
		do_op(OP_WRITE, 13'h0200, 8'h11);
		do_op(OP_READ, 13'h0f0f, 8'h00);
		check(nvmem_dev_model_i.stores, base);
	endtask : t_abort

	task automatic t_sw;
		time t0;
		do_op(OP_WRITE, 13'h0123, 8'h5a);
		t0 = $time;
		do_op(OP_STORE_SW, 13'h0000, 8'h00);
		check(nvmem_dev_model_i.stores, base + 1);
		check(nvmem_dev_model_i.nv[13'h0123], 8'h5a);
		check($time - t0 >= 20000, 1'b1);
		do_op(OP_WRITE, 13'h0123, 8'h81);
		do_op(OP_RECALL_SW, 13'h0000, 8'h00);
		do_op(OP_READ, 13'h0123, 8'h00);
		check(got, 8'h5a);
		check(nvmem_dev_model_i.stores, base + 1);
	endtask : t_sw

	task automatic t_hw;
		do_op(OP_STORE_HW, 13'h0000, 8'h00);
		check(nvmem_dev_model_i.stores, base + 1);
		do_op(OP_WRITE, 13'h0456, 8'hc3);
		do_op(OP_STORE_HW, 13'h0000, 8'h00);
		check(nvmem_dev_model_i.stores, base + 2);
		check(nvmem_dev_model_i.nv[13'h0456], 8'hc3);
		do_op(OP_READ, 13'h0456, 8'h00);
		check(got, 8'hc3);
	endtask : t_hw

	task automatic t_pf;
		store_inhibit = 1'b1;
		do_op(OP_WRITE, 13'h0789, 8'h96);
		pulse_pf;
		check(nvmem_dev_model_i.stores, base + 2);
		check(nvmem_dev_model_i.pull, 1'b0);
		store_inhibit = 1'b0;
		pulse_pf;
		check(hsb_i, 1'b0);
		do_op(OP_READ, 13'h0789, 8'h00);
		check(got, 8'h96);
		check(nvmem_dev_model_i.nv[13'h0789], 8'h96);
	endtask : t_pf

	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_rw;
		t_abort;
		t_sw;
		t_hw;
		t_pf;
		wrap_up;
	end
endmodule : nonvolatile_sram_mode_control_bench

//--- tb/nvmem_dev_model.sv
// Behavioural model of the 8K x 8 memory with nonvolatile shadow
`timescale 1ns/1ps
`include "nvmem_defines.svh"

module nvmem_dev_model #(
	parameter int STORE_NS  = 20000,
	parameter int RECALL_NS = 100
) (
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [12:0] addr,
	input  wire logic [7:0]  dq_o,
	input  wire logic        dq_oe_n,
	input  wire logic        hsb_o,
	input  wire logic        hsb_oe_n,
	input  wire logic        pf,
	output logic      [7:0]  dq_i,
	output logic             hsb_i
);
	// ==========================================================
	// State
	logic [7:0]  mem [8192];
	logic [7:0]  nv [8192];
	logic [7:0]  flt = 8'h5a;
	logic [12:0] cyc_addr;
	logic [12:0] seq [5] = '{`NV_SEQ_A0, `NV_SEQ_A1, `NV_SEQ_A2,
		`NV_SEQ_A3, `NV_SEQ_A4};
	logic [2:0]  idx = 3'h0;
	logic        busy = 1'b0;
	logic        stby = 1'b0;
	logic        pull = 1'b0;
	logic        dirty = 1'b0;
	logic        wr_cyc = 1'b0;
	int          stores = 0;
	wire  [7:0]  dq_dly;
	wire         ok = !busy && !stby && hsb_i;
	wire         dev_drv = !ce_n && we_n && !oe_n && ok;
	wire         wr_act = !ce_n && !we_n && ok;

	// Released bus never holds a stable byte
	always #20 flt = ~flt;
	assign dq_i = !dq_oe_n ? dq_o : (dev_drv ? mem[addr] : flt);
	// Host driver overpowers the pull-down; idle line pulled up
	assign hsb_i = !hsb_oe_n ? hsb_o : !pull;
	// Data hold past the strobe edge
	assign #1 dq_dly = dq_i;

	task automatic store_run;
		busy = 1'b1;
		pull = 1'b1;
		#(STORE_NS);
		nv = mem;
		dirty = 1'b0;
		stores++;
		pull = 1'b0;
		busy = 1'b0;
	endtask : store_run

	// ==========================================================
	// Access and sequence detection
	always @(negedge ce_n) begin
		cyc_addr = addr;
		wr_cyc = 1'b0;
	end
	always @(negedge wr_act) begin
		mem[cyc_addr] = dq_dly;
		dirty = 1'b1;
		wr_cyc = 1'b1;
	end
	// Judged after the cycle so a write ending at the same edge counts
	always @(posedge ce_n) begin
		#2;
		if (!ok || wr_cyc) idx = 3'h0;
		else if (idx == `NV_SEQ_LAST) begin
			idx = 3'h0;
			if (cyc_addr == `NV_SEQ_STORE) store_run;
			else if (cyc_addr == `NV_SEQ_RECALL) begin
				busy = 1'b1;
				#(RECALL_NS);
				mem = nv;
				dirty = 1'b0;
				busy = 1'b0;
			end
		end else if (cyc_addr == seq[idx]) idx++;
		else idx = (cyc_addr == seq[0]) ? 3'h1 : 3'h0;
	end
	always @(negedge hsb_i) begin
		if (!pull && !busy) begin
			if (dirty) store_run;
			stby = 1'b1;
			wait (hsb_i === 1'b1);
			stby = 1'b0;
		end
	end
	always @(posedge pf) begin
		pull = 1'b1;
		#10;
		if (hsb_i !== 1'b0) pull = 1'b0;
		else store_run;
	end
endmodule : nvmem_dev_model
